// ### pkg/sio_pkg.sv
// Purpose: Constants and carrier types for the shared I/O port with module gating
// Assumes: One 16-pin port, AXI4-Lite register access, 32-bit data bus
// Notes: Pin ownership and analog capability are fixed tables below
package sio_pkg;
	localparam int NPIN = 16;
	localparam int NMOD = 13;
	localparam int AXI_AW = 8;

	// Register byte offsets
	localparam logic [7:0] GATE_A_OFS = 8'h00;
	localparam logic [7:0] GATE_B_OFS = 8'h04;
	localparam logic [7:0] DIR_OFS = 8'h08;
	localparam logic [7:0] LAT_OFS = 8'h0C;
	localparam logic [7:0] PINST_OFS = 8'h10;
	localparam logic [7:0] ODC_OFS = 8'h14;
	localparam logic [7:0] ACFG_OFS = 8'h18;

	// Field positions in peripheral_gate_a
	localparam int GA_TIMER_C_OFF = 13;
	localparam int GA_TIMER_B_OFF = 12;
	localparam int GA_TIMER_A_OFF = 11;
	localparam int GA_TWO_WIRE_UNIT_OFF = 7;
	localparam int GA_ASYNC_SERIAL_OFF = 5;
	localparam int GA_SYNC_SERIAL_OFF = 3;
	localparam int GA_CONVERTER_OFF = 0;
	// Field positions in peripheral_gate_b
	localparam int GB_CAPTURE_H_OFF = 15;
	localparam int GB_CAPTURE_G_OFF = 14;
	localparam int GB_CAPTURE_B_OFF = 9;
	localparam int GB_CAPTURE_A_OFF = 8;
	localparam int GB_COMPARE_B_OFF = 1;
	localparam int GB_COMPARE_A_OFF = 0;

	// Implemented bits; everything else reads zero
	localparam logic [15:0] GATE_A_MASK = 16'h38A9;
	localparam logic [15:0] GATE_B_MASK = 16'hC303;

	// Reset values
	localparam logic [15:0] GATE_RST = 16'h0000;
	localparam logic [15:0] LAT_RST = 16'h0000;
	localparam logic [15:0] ODC_RST = 16'h0000;
	localparam logic [15:0] ACFG_RST = 16'h0000;

	// Pins bonded out on this variant, and pins shared with converter inputs
	localparam logic [15:0] PIN_VALID = 16'h7FFF;
	localparam logic [15:0] CONV_PIN_MASK = 16'h003F;
	localparam logic [15:0] DIR_RST = PIN_VALID;

	// Index of each gated module on the module_on vector
	typedef enum logic [3:0] {
		MOD_TIMER_A = 4'h0,
		MOD_TIMER_B = 4'h1,
		MOD_TIMER_C = 4'h2,
		MOD_TWO_WIRE = 4'h3,
		MOD_ASYNC_SERIAL = 4'h4,
		MOD_SYNC_SERIAL = 4'h5,
		MOD_CONVERTER = 4'h6,
		MOD_CAPTURE_A = 4'h7,
		MOD_CAPTURE_B = 4'h8,
		MOD_CAPTURE_G = 4'h9,
		MOD_CAPTURE_H = 4'hA,
		MOD_COMPARE_A = 4'hB,
		MOD_COMPARE_B = 4'hC,
		MOD_NONE = 4'hF
	} sio_mod_t;

	// Output-capable peripheral owning each pin; input-only sharers count as none
	localparam sio_mod_t PIN_OWNER [NPIN] = '{
		MOD_NONE, MOD_NONE, MOD_NONE, MOD_NONE, MOD_NONE, MOD_NONE,
		MOD_SYNC_SERIAL, MOD_SYNC_SERIAL, MOD_ASYNC_SERIAL, MOD_TWO_WIRE,
		MOD_TWO_WIRE, MOD_COMPARE_A, MOD_COMPARE_B, MOD_NONE, MOD_NONE, MOD_NONE
	};

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Pad drive pair for one pin
	typedef struct packed {
		logic out;
		logic oe;
	} sio_pad_t;
endpackage : sio_pkg

// ### rtl/sio_sync2.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels, not pulses
// Notes: Only the second stage may be read by other logic
`timescale 1ns/10ps
module sio_sync2 #(
	parameter int W = 16
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_r;

	// First stage feeds nothing but the second
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_r <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule : sio_sync2

// ### rtl/sio_pin_cell.sv
// Purpose: Ownership and drive mux for one shared pin
// Assumes: Inputs come from the same clock domain, already synchronised
// Notes: Purely combinational; the top registers the results
`timescale 1ns/10ps
module sio_pin_cell
	import sio_pkg::*;
(
	input wire logic dir_i,
	input wire logic lat_i,
	input wire logic odc_i,
	input wire logic valid_i,
	input wire logic analog_i,
	input wire logic owner_on_i,
	input wire logic periph_drive_i,
	input wire logic periph_dout_i,
	input wire logic pin_lvl_i,
	output sio_pad_t pad_o,
	output logic port_rd_o,
	output logic periph_din_o
);
	logic periph_owns;
	logic src_data;
	logic src_en;
	logic port_drives;
	logic digital_lvl;

	// Peripheral wins only while enabled and actively driving
	assign periph_owns = owner_on_i & periph_drive_i;
	assign src_data = periph_owns ? periph_dout_i : lat_i;
	assign src_en = valid_i & (periph_owns | ~dir_i);
	assign port_drives = src_en & ~periph_owns;

	// Open drain only ever pulls low; a one releases the pin
	assign pad_o.oe = src_en & (~odc_i | ~src_data);
	assign pad_o.out = odc_i ? 1'b0 : src_data;

	// Analog pins read low through the digital path
	assign digital_lvl = valid_i & ~analog_i & pin_lvl_i;
	assign port_rd_o = digital_lvl;
	// Block the port's own drive from looping into the peripheral input
	assign periph_din_o = port_drives ? 1'b0 : digital_lvl;
endmodule : sio_pin_cell

// ### rtl/sio_port_top.sv
// Purpose: Shared I/O port with peripheral module gating, AXI4-Lite slave
// Assumes: pad_in_i is asynchronous; peripheral signals share sys_clk_i
// Notes: Pad and gate outputs lag the controlling register by one cycle
//        Only the low 16 bits of write data and two strobes matter; unmapped addresses answer an error
// How it works
// - Gate A bits 13, 12, 11 stop timers C, B, A when one.
// - Gate A bits 7, 5, 3 stop two-wire, async serial, sync serial.
// - Gate A bit 0 stops converter and forces its pins digital.
// - Unimplemented gate bits read zero; implemented ones reset to zero.
// - Gate B bits 15, 14, 9, 8 stop captures H, G, B, A.
// - Gate B bits 1 and 0 stop compares B and A.
// - Per pin, a mux picks peripheral or port data and enable.
// - Port drive never loops back into the sharing peripheral input.
// - Actively driving enabled peripheral disables port driver; pin still readable.
// - Enabled but idle peripheral lets the port drive the pin.
// - Direction bit one means input, zero means output.
// - Every pin is an input after reset.
// - Output latch reads back stored value; writes update it.
// - Pin state reads pin levels; writes go to the latch.
// - Absent pins read zero in latch, direction and pin state.
// - Pins shared only with input functions act as plain port pins.
// - Open-drain select bit makes that pin's output open drain.
// - Gate bit change reaches the module one cycle after write.
// - Gated module ignores register writes; its reads are undefined.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module sio_port_top
	import sio_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NPIN-1:0] pad_in_i,
	output logic [NPIN-1:0] pad_out_o,
	output logic [NPIN-1:0] pad_oe_o,
	input wire logic [NMOD-1:0] periph_en_i,
	input wire logic [NPIN-1:0] periph_drive_i,
	input wire logic [NPIN-1:0] periph_dout_i,
	output logic [NPIN-1:0] periph_din_o,
	output logic [NMOD-1:0] module_on_o,
	output logic digital_force_o
);
	// All state except the pin synchroniser in one record
	typedef struct packed {
		// Software-visible registers
		logic [15:0] gate_a;
		logic [15:0] gate_b;
		logic [15:0] dir;
		logic [15:0] lat;
		logic [15:0] odc;
		logic [15:0] acfg;
		// Registered outputs toward pins and peripherals
		logic [NMOD-1:0] mod_on;
		logic conv_digital;
		logic [NPIN-1:0] pad_out;
		logic [NPIN-1:0] pad_oe;
		logic [NPIN-1:0] periph_din;
		// Register bus slave bookkeeping
		logic aw_have;
		logic [AXI_AW-1:0] awaddr;
		logic w_have;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sio_state_t;

	// Current and next copy of the whole record
	sio_state_t st_r;
	sio_state_t st_nxt;

	// Helpers between the pin cells and the state record
	logic [NPIN-1:0] pin_lvl;
	logic [NPIN-1:0] port_rd;
	logic [NPIN-1:0] analog;
	logic [NPIN-1:0] owner_on;
	logic [NMOD-1:0] gate_vec;
	sio_pad_t pad [NPIN];
	logic [NPIN-1:0] cell_out;
	logic [NPIN-1:0] cell_oe;
	logic [NPIN-1:0] cell_din;

	// Pins come from outside the clock domain
	sio_sync2 #(
		.W(NPIN)
	) u_pin_sync (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.async_i(pad_in_i),
		.sync_o(pin_lvl)
	);

	// Disable bits gathered into module order
	always_comb
	begin
		gate_vec = '0;
		gate_vec[MOD_TIMER_A] = st_r.gate_a[GA_TIMER_A_OFF];
		gate_vec[MOD_TIMER_B] = st_r.gate_a[GA_TIMER_B_OFF];
		gate_vec[MOD_TIMER_C] = st_r.gate_a[GA_TIMER_C_OFF];
		gate_vec[MOD_TWO_WIRE] = st_r.gate_a[GA_TWO_WIRE_UNIT_OFF];
		gate_vec[MOD_ASYNC_SERIAL] = st_r.gate_a[GA_ASYNC_SERIAL_OFF];
		gate_vec[MOD_SYNC_SERIAL] = st_r.gate_a[GA_SYNC_SERIAL_OFF];
		gate_vec[MOD_CONVERTER] = st_r.gate_a[GA_CONVERTER_OFF];
		// Second register: captures and compares
		gate_vec[MOD_CAPTURE_A] = st_r.gate_b[GB_CAPTURE_A_OFF];
		gate_vec[MOD_CAPTURE_B] = st_r.gate_b[GB_CAPTURE_B_OFF];
		gate_vec[MOD_CAPTURE_G] = st_r.gate_b[GB_CAPTURE_G_OFF];
		gate_vec[MOD_CAPTURE_H] = st_r.gate_b[GB_CAPTURE_H_OFF];
		gate_vec[MOD_COMPARE_A] = st_r.gate_b[GB_COMPARE_A_OFF];
		gate_vec[MOD_COMPARE_B] = st_r.gate_b[GB_COMPARE_B_OFF];
	end

	// Analog config is ignored while the converter is gated off
	assign analog = CONV_PIN_MASK & ~st_r.acfg & {NPIN{st_r.mod_on[MOD_CONVERTER]}};

	// One mux cell per pin
	generate
		for (genvar p = 0; p < NPIN; p++)
		begin : g_pin
			// Unowned pins, including input-only sharers, stay with the port
			if (PIN_OWNER[p] == MOD_NONE)
			begin : g_dedicated
				assign owner_on[p] = 1'b0;
			end
			else
			begin : g_shared
				// A gated peripheral never counts as enabled
				assign owner_on[p] = periph_en_i[PIN_OWNER[p]] & st_r.mod_on[PIN_OWNER[p]];
			end
			// Every input of the cell is already in this clock domain
			sio_pin_cell u_cell (
				.dir_i(st_r.dir[p]),
				.lat_i(st_r.lat[p]),
				.odc_i(st_r.odc[p]),
				.valid_i(PIN_VALID[p]),
				.analog_i(analog[p]),
				.owner_on_i(owner_on[p]),
				.periph_drive_i(periph_drive_i[p]),
				.periph_dout_i(periph_dout_i[p]),
				.pin_lvl_i(pin_lvl[p]),
				.pad_o(pad[p]),
				.port_rd_o(port_rd[p]),
				.periph_din_o(cell_din[p])
			);
			// Flatten the pad record for the next-state logic
			assign cell_out[p] = pad[p].out;
			assign cell_oe[p] = pad[p].oe;
		end
	endgenerate

	// Next-state logic: bus slave, registers and pin outputs
	always_comb
	begin
		logic [15:0] wr_val;
		logic [15:0] wr_mask;
		logic [15:0] rd_val;
		logic rd_hit;
		logic wr_hit;
		// Locals first, so no path leaves one unassigned
		wr_mask = {{8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
		wr_val = 16'h0000;
		rd_val = 16'h0000;
		rd_hit = 1'b1;
		wr_hit = 1'b1;

		// Everything holds unless a branch below says otherwise
		st_nxt = st_r;

		// Module enables follow the gate registers a cycle late
		st_nxt.mod_on = ~gate_vec;
		st_nxt.conv_digital = gate_vec[MOD_CONVERTER];

		// Pads are registered so the pins never show mux glitches
		st_nxt.pad_out = cell_out;
		st_nxt.pad_oe = cell_oe;
		st_nxt.periph_din = cell_din;

		// Address and data are caught independently, in either order
		if (s_axi_awvalid && st_r.awready)
		begin
			st_nxt.aw_have = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		// Registers are 16 bits, so only the low data half and two strobes are kept
		if (s_axi_wvalid && st_r.wready)
		begin
			st_nxt.w_have = 1'b1;
			st_nxt.wdata = s_axi_wdata[15:0];
			st_nxt.wstrb = s_axi_wstrb[1:0];
		end

		// Commit a write once both halves are held
		if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
		begin
			unique case (st_r.awaddr)
				// Unimplemented disable bits are dropped here, so they read zero
				GATE_A_OFS:
				begin
					wr_val = (st_r.gate_a & ~wr_mask) | (st_r.wdata & wr_mask);
					st_nxt.gate_a = wr_val & GATE_A_MASK;
				end
				// Same masking for the second gate register
				GATE_B_OFS:
				begin
					wr_val = (st_r.gate_b & ~wr_mask) | (st_r.wdata & wr_mask);
					st_nxt.gate_b = wr_val & GATE_B_MASK;
				end
				// Absent pins keep a zero direction bit
				DIR_OFS:
				begin
					wr_val = (st_r.dir & ~wr_mask) | (st_r.wdata & wr_mask);
					st_nxt.dir = wr_val & PIN_VALID;
				end
				// One latch behind two write addresses
				LAT_OFS, PINST_OFS:
				begin
					// Writes to the pin state land in the latch
					wr_val = (st_r.lat & ~wr_mask) | (st_r.wdata & wr_mask);
					st_nxt.lat = wr_val & PIN_VALID;
				end
				// Open-drain select, absent pin masked
				ODC_OFS:
				begin
					wr_val = (st_r.odc & ~wr_mask) | (st_r.wdata & wr_mask);
					st_nxt.odc = wr_val & PIN_VALID;
				end
				// Only converter-shared pins keep a config bit
				ACFG_OFS:
				begin
					wr_val = (st_r.acfg & ~wr_mask) | (st_r.wdata & wr_mask);
					st_nxt.acfg = wr_val & CONV_PIN_MASK;
				end
				// Unmapped address: answer with an error, change nothing
				default:
				begin
					wr_hit = 1'b0;
				end
			endcase
			// Both halves consumed; the answer waits for bready
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		// Write answer leaves at the edge that sees bready
		if (st_r.bvalid && s_axi_bready)
		begin
			st_nxt.bvalid = 1'b0;
		end

		// Read: one outstanding, answered the cycle after address accept
		if (s_axi_arvalid && st_r.arready)
		begin
			unique case (s_axi_araddr)
				GATE_A_OFS: rd_val = st_r.gate_a;
				GATE_B_OFS: rd_val = st_r.gate_b;
				DIR_OFS: rd_val = st_r.dir;
				LAT_OFS: rd_val = st_r.lat;
				// Pin state is the synchronised pins, never the latch
				PINST_OFS: rd_val = port_rd;
				ODC_OFS: rd_val = st_r.odc;
				ACFG_OFS: rd_val = st_r.acfg;
				default: rd_hit = 1'b0;
			endcase
			// Answer next cycle; the upper half of the word always reads zero
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = {16'h0000, rd_val};
			st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (st_r.rvalid && s_axi_rready)
		begin
			st_nxt.rvalid = 1'b0;
		end

		// Ready lines refuse while a half is held or an answer waits
		st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;
	end

	// State register; pins come up as inputs with all modules enabled
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			// Clear everything, then lay the reset values on top
			st_r <= '0;
			st_r.gate_a <= GATE_RST;
			st_r.gate_b <= GATE_RST;
			st_r.dir <= DIR_RST;
			st_r.lat <= LAT_RST;
			st_r.odc <= ODC_RST;
			st_r.acfg <= ACFG_RST;
			// Modules enabled and bus ready to accept straight after reset
			st_r.mod_on <= '1;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state record
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;

	// Pad drive and the filtered pin feed to the peripherals
	assign pad_out_o = st_r.pad_out;
	assign pad_oe_o = st_r.pad_oe;
	assign periph_din_o = st_r.periph_din;

	// Gate state as the peripherals see it; they ignore register writes while off
	assign module_on_o = st_r.mod_on;
	assign digital_force_o = st_r.conv_digital;
endmodule : sio_port_top

// ### dv/sio_port_chk.sv
// Purpose: Port-level checker for the shared I/O port
// Assumes: Bound to sio_port_top, one clock domain
// Notes: Pads and gates lag their cause by one register stage
`timescale 1ns/10ps
module sio_port_chk
	import sio_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NPIN-1:0] pad_out_o,
	input wire logic [NPIN-1:0] pad_oe_o,
	input wire logic [NMOD-1:0] periph_en_i,
	input wire logic [NPIN-1:0] periph_drive_i,
	input wire logic [NPIN-1:0] periph_dout_i,
	input wire logic [NMOD-1:0] module_on_o,
	input wire logic digital_force_o
);
	// Reset disables every check, so values held over reset never count
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer not on time");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not on time");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	AST_ABSENT: assert property (!pad_oe_o[NPIN-1] && !pad_out_o[NPIN-1])
		else $error("absent pin driven");
	AST_FORCE: assert property (digital_force_o == !module_on_o[6])
		else $error("digital force differs from converter gate");
	AST_GATE_DLY: assert property ($changed(module_on_o) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("gate change without a recent write");
	AST_OWN: assert property ((periph_en_i[11] && periph_drive_i[11] && module_on_o[11]) ##1 module_on_o[11]
		|-> pad_oe_o[11] && pad_out_o[11] == $past(periph_dout_i[11]))
		else $error("driving peripheral does not own its pin");
endmodule : sio_port_chk

bind sio_port_top sio_port_chk sio_port_chk_inst (
	.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .periph_en_i(periph_en_i), .periph_drive_i(periph_drive_i),
	.periph_dout_i(periph_dout_i), .module_on_o(module_on_o), .digital_force_o(digital_force_o)
);

// ### dv/sio_pin_model.sv
// Purpose: External circuit on the port pins
// Assumes: A pull-up on every pin and an optional outside driver
// Notes: Device drive wins; a fight is not modelled
`timescale 1ns/10ps
module sio_pin_model
	import sio_pkg::*;
(
	input wire logic [NPIN-1:0] pad_out_i,
	input wire logic [NPIN-1:0] pad_oe_i,
	input wire logic [NPIN-1:0] ext_en_i,
	input wire logic [NPIN-1:0] ext_val_i,
	output logic [NPIN-1:0] pad_in_o
);
	// Released pins rise through the pull-up, so open drain reads high
	assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule : sio_pin_model

// ### dv/tb.sv
// Purpose: Self-checking bench for the shared I/O port
// Assumes: Handshakes sampled mid-cycle, driven just after rising edges
// Notes: Register offsets follow the package map
`timescale 1ns/10ps
module tb
	import sio_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic brd = 1'b0;
	logic arv = 1'b0;
	logic rrd = 1'b0;
	logic [3:0] ws = 4'hF;
	logic awrdy, wrdy, bv, arrdy, rv, dfor;
	logic [1:0] br, rresp;
	logic [31:0] rdat;
	logic [15:0] pin, pout, poe, pdin;
	logic [15:0] pdrv = 16'h0000;
	logic [15:0] pdo = 16'h0000;
	logic [15:0] exe = 16'h0000;
	logic [15:0] exv = 16'h0000;
	logic [12:0] pen = 13'h0000;
	logic [12:0] mon;
	int n_fail = 0;
	int samples_checked = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	sio_port_top sio_port_top_inst (
		.sys_clk_i(clk), .arst_n_i(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .pad_in_i(pin),
		.pad_out_o(pout), .pad_oe_o(poe), .periph_en_i(pen), .periph_drive_i(pdrv), .periph_dout_i(pdo),
		.periph_din_o(pdin), .module_on_o(mon), .digital_force_o(dfor)
	);

	sio_pin_model sio_pin_model_inst (
		.pad_out_i(pout), .pad_oe_i(poe), .ext_en_i(exe), .ext_val_i(exv), .pad_in_o(pin)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Write: handshakes judged at the falling edge, released after the next rise
	task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic ha, hw, hb;
		@(posedge clk);
		awa <= a;
		wd <= {16'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		hb = 1'b0;
		while (!hb)
		begin
			@(negedge clk);
			ha = awv && awrdy;
			hw = wv && wrdy;
			hb = bv;
			if (hb)
				chk({30'h0, br}, {30'h0, er});
			@(posedge clk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
		end
		brd <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		logic ha, hr;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		hr = 1'b0;
		while (!hr)
		begin
			@(negedge clk);
			ha = arv && arrdy;
			hr = rv;
			d = rdat;
			if (hr)
				chk({30'h0, rresp}, {30'h0, er});
			@(posedge clk);
			if (ha) arv <= 1'b0;
		end
		rrd <= 1'b0;
	endtask : axr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		axr(a, 2'b00, d);
		chk(d, e);
	endtask : rc

	// Covers register stage, output stage and the two-flop pin synchroniser
	task automatic settle;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic t_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk({19'h0, mon}, {19'h0, 13'h1FFF});
		chk({16'h0, poe}, 32'h0);
		rc(8'h00, 32'h0);
		rc(8'h04, 32'h0);
		rc(8'h08, 32'h7FFF);
		rc(8'h0C, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_gate;
		int bitpos [13] = '{11, 12, 13, 7, 5, 3, 0, 8, 9, 14, 15, 0, 1};
		logic [15:0] v;
		axw(8'h00, 16'hFFFF, 2'b00);
		axw(8'h04, 16'hFFFF, 2'b00);
		rc(8'h00, 32'h38A9);
		rc(8'h04, 32'hC303);
		for (int i = 0; i < 13; i++)
		begin
			v = 16'h0001 << bitpos[i];
			axw(8'h00, (i < 7) ? v : 16'h0000, 2'b00);
			axw(8'h04, (i < 7) ? 16'h0000 : v, 2'b00);
			settle();
			chk({19'h0, mon}, {19'h0, ~(13'h0001 << i)});
			chk({31'h0, dfor}, {31'h0, i == 6});
		end
		axw(8'h04, 16'h0000, 2'b00);
		$display("test gate done");
	endtask : t_gate

	task automatic t_port;
		axw(8'h18, 16'h003F, 2'b00);
		axw(8'h08, 16'h0000, 2'b00);
		axw(8'h0C, 16'hDA5A, 2'b00);
		settle();
		chk({16'h0, poe}, 32'h7FFF);
		chk({16'h0, pout}, 32'h5A5A);
		chk({16'h0, pdin}, 32'h0);
		rc(8'h08, 32'h0);
		rc(8'h0C, 32'h5A5A);
		rc(8'h10, 32'h5A5A);
		axw(8'h10, 16'h00F0, 2'b00);
		rc(8'h0C, 32'h00F0);
		axw(8'h14, 16'h0003, 2'b00);
		axw(8'h0C, 16'h0001, 2'b00);
		settle();
		chk({30'h0, poe[1:0]}, {30'h0, 2'b10});
		rc(8'h10, 32'h0001);
		axw(8'h08, 16'hFFFF, 2'b00);
		exe <= 16'hFFFF;
		exv <= 16'hB2C4;
		settle();
		chk({16'h0, poe}, 32'h0);
		rc(8'h08, 32'h7FFF);
		rc(8'h10, 32'h32C4);
		chk({16'h0, pdin}, 32'h32C4);
		axw(8'h18, 16'h0000, 2'b00);
		rc(8'h10, 32'h32C0);
		axw(8'h00, 16'h0001, 2'b00);
		settle();
		rc(8'h10, 32'h32C4);
		axw(8'h00, 16'h0000, 2'b00);
		exe <= 16'h0000;
		$display("test port done");
	endtask : t_port

	task automatic t_periph;
		logic [31:0] d;
		axw(8'h08, 16'h0000, 2'b00);
		axw(8'h0C, 16'h0000, 2'b00);
		axw(8'h14, 16'h0000, 2'b00);
		pen <= 13'h1FFF;
		pdrv <= 16'h0800;
		pdo <= 16'h0800;
		settle();
		chk({30'h0, poe[11], pout[11]}, {30'h0, 2'b11});
		axr(8'h10, 2'b00, d);
		chk(d & 32'h0800, 32'h0800);
		@(posedge clk);
		pdrv <= 16'h0000;
		settle();
		chk({30'h0, poe[11], pout[11]}, {30'h0, 2'b10});
		@(posedge clk);
		pdrv <= 16'h0800;
		axw(8'h04, 16'h0001, 2'b00);
		settle();
		chk({30'h0, poe[11], pout[11]}, {30'h0, 2'b10});
		axw(8'h04, 16'h0000, 2'b00);
		pdrv <= 16'h0000;
		$display("test periph done");
	endtask : t_periph

	task automatic t_bus;
		logic [31:0] d;
		axw(8'h0C, 16'h00FF, 2'b00);
		axw(8'h40, 16'h1234, 2'b10);
		axr(8'h40, 2'b10, d);
		chk(d, 32'h0);
		rc(8'h0C, 32'h00FF);
		// Upper byte strobe only: the low latch byte must survive
		ws <= 4'h2;
		axw(8'h0C, 16'h3412, 2'b00);
		ws <= 4'hF;
		rc(8'h0C, 32'h34FF);
		$display("test bus done");
	endtask : t_bus

	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	// Main sequence; the second reset also proves registers return to defaults
	initial
	begin
		t_reset();
		t_gate();
		t_port();
		t_periph();
		t_bus();
		t_reset();
		results();
	end

	// Watchdog sized well past the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		results();
	end
endmodule : tb
